// ---- src/cpu_register_file.v ----
// banked cpu register file with one-megabyte address map decoder
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "cpu_regs_map.vh"

module cpu_register_file #(
	parameter [19:0] ROM_SIZE = `ROM_SIZE_DEF,
	parameter [19:0] RAM_SIZE = `RAM_SIZE_DEF
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire [1:0]  wsize,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire [3:0]  src_a_sel,
	input  wire [1:0]  src_a_size,
	input  wire [3:0]  src_b_sel,
	input  wire [1:0]  src_b_size,
	output reg  [31:0] src_a,
	output reg  [31:0] src_b,
	input  wire [19:0] mem_addr,
	output reg  [2:0]  mem_region,
	output reg  [19:0] pc_out,
	output reg  [15:0] stack_pointer,
	output reg  [15:0] frame_base_out,
	output reg  [19:0] vector_base_out,
	output reg         bank_sel_out
);

	// two banks of seven: data 0..3, pointer 0..1, frame base
	reg [15:0] bank_regs [0:13];
	reg [19:0] vector_table_base;
	reg [19:0] program_counter;
	reg [15:0] user_stack_pointer;
	reg [15:0] interrupt_stack_pointer;
	reg        bank_flag;
	reg        stack_flag;
	integer    i;

	// index into the banked array for a selector
	function [3:0] bank_index;
		input [3:0] sel;
		input       bank;
		begin
			bank_index = (bank ? 4'h7 : 4'h0) + sel;
		end
	endfunction

	// read a register, widened or paired as the size asks
	function [31:0] read_reg;
		input [3:0] sel;
		input [1:0] size;
		input       bank;
		reg   [15:0] word;
		begin
			word = 16'h0000;
			read_reg = 32'h00000000;
			if (sel <= `SEL_FRAME)
				word = bank_regs[bank_index(sel, bank)];
			case (sel)
			`SEL_DATA0, `SEL_DATA1: begin
				if (size == `SZ_LOW_BYTE)
					read_reg = {24'h000000, word[7:0]};
				else if (size == `SZ_HIGH_BYTE)
					read_reg = {24'h000000, word[15:8]};
				else if (size == `SZ_PAIR)
					read_reg = {bank_regs[bank_index(sel + 4'h2, bank)],
						word};
				else
					read_reg = {16'h0000, word};
			end
			`SEL_DATA2, `SEL_DATA3, `SEL_FRAME:
				read_reg = {16'h0000, word};
			`SEL_PTR0, `SEL_PTR1: begin
				if (size == `SZ_PAIR)
					read_reg = {bank_regs[bank_index(`SEL_PTR1, bank)],
						bank_regs[bank_index(`SEL_PTR0, bank)]};
				else
					read_reg = {16'h0000, word};
			end
			`SEL_VTB:
				read_reg = {12'h000, vector_table_base};
			`SEL_PC:
				read_reg = {12'h000, program_counter};
			`SEL_USP:
				read_reg = {16'h0000, user_stack_pointer};
			`SEL_ISP:
				read_reg = {16'h0000, interrupt_stack_pointer};
			`SEL_FLAGS:
				read_reg = {30'h00000000, stack_flag, bank_flag};
			default:
				read_reg = 32'h00000000;
			endcase
		end
	endfunction

	// region decode; rom and ram limits follow their sizes
	function [2:0] decode;
		input [19:0] a;
		reg   [19:0] rom_low;
		reg   [19:0] ram_end;
		begin
			rom_low = `ADDR_TOP - ROM_SIZE + 20'h00001;
			ram_end = `RAM_BASE + RAM_SIZE;
			// vector tables sit inside rom and take priority
			if (a >= `FIXED_VEC_FIRST)
				decode = `REG_FIXED;
			else if (a >= `SPECIAL_FIRST)
				decode = `REG_SPECIAL;
			else if (a >= rom_low)
				decode = `REG_ROM;
			else if (a <= `PERIPH_LAST)
				decode = `REG_PERIPH;
			else if (a < ram_end)
				decode = `REG_RAM;
			else
				decode = `REG_UNMAPPED;
		end
	endfunction

	// register writes; a byte write to data 0 or 1 keeps the other byte
	always @(posedge clk) begin
		if (rst) begin
			for (i = 0; i < 14; i = i + 1)
				bank_regs[i] <= 16'h0000;
			vector_table_base <= `RESET_VALUE;
			program_counter <= `RESET_VALUE;
			user_stack_pointer <= 16'h0000;
			interrupt_stack_pointer <= 16'h0000;
			bank_flag <= 1'b0;
			stack_flag <= 1'b0;
		end else if (wr) begin
			case (addr)
			`SEL_DATA0, `SEL_DATA1: begin
				if (wsize == `SZ_LOW_BYTE)
					bank_regs[bank_index(addr, bank_flag)][7:0]
						<= wdata[7:0];
				else if (wsize == `SZ_HIGH_BYTE)
					bank_regs[bank_index(addr, bank_flag)][15:8]
						<= wdata[7:0];
				else if (wsize == `SZ_PAIR) begin
					bank_regs[bank_index(addr, bank_flag)]
						<= wdata[15:0];
					bank_regs[bank_index(addr + 4'h2, bank_flag)]
						<= wdata[31:16];
				end else
					bank_regs[bank_index(addr, bank_flag)]
						<= wdata[15:0];
			end
			`SEL_DATA2, `SEL_DATA3, `SEL_FRAME:
				bank_regs[bank_index(addr, bank_flag)]
					<= wdata[15:0];
			`SEL_PTR0, `SEL_PTR1: begin
				if (wsize == `SZ_PAIR) begin
					bank_regs[bank_index(`SEL_PTR0, bank_flag)]
						<= wdata[15:0];
					bank_regs[bank_index(`SEL_PTR1, bank_flag)]
						<= wdata[31:16];
				end else
					bank_regs[bank_index(addr, bank_flag)]
						<= wdata[15:0];
			end
			`SEL_VTB:
				vector_table_base <= wdata[19:0];
			`SEL_PC:
				program_counter <= wdata[19:0];
			`SEL_USP:
				user_stack_pointer <= wdata[15:0];
			`SEL_ISP:
				interrupt_stack_pointer <= wdata[15:0];
			`SEL_FLAGS: begin
				bank_flag <= wdata[`FLAG_BANK];
				stack_flag <= wdata[`FLAG_STACK];
			end
			default: ;
			endcase
		end
	end

	// registered outputs; values trail the state by one cycle
	always @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h00000000;
			src_a <= 32'h00000000;
			src_b <= 32'h00000000;
			mem_region <= `REG_PERIPH;
			pc_out <= `RESET_VALUE;
			stack_pointer <= 16'h0000;
			frame_base_out <= 16'h0000;
			vector_base_out <= `RESET_VALUE;
			bank_sel_out <= 1'b0;
		end else begin
			// read data only in the cycle after the strobe
			rdata <= rd ? read_reg(addr, wsize, bank_flag)
				: 32'h00000000;
			src_a <= read_reg(src_a_sel, src_a_size, bank_flag);
			src_b <= read_reg(src_b_sel, src_b_size, bank_flag);
			mem_region <= decode(mem_addr);
			pc_out <= program_counter;
			// stack flag one picks the user pointer
			stack_pointer <= stack_flag ? user_stack_pointer
				: interrupt_stack_pointer;
			frame_base_out <= bank_regs[bank_index(`SEL_FRAME,
				bank_flag)];
			vector_base_out <= vector_table_base;
			bank_sel_out <= bank_flag;
		end
	end

endmodule // cpu_register_file

// ---- src/cpu_regs_map.vh ----
// address map limits, register selector codes and field positions
`ifndef CPU_REGS_MAP_VH
`define CPU_REGS_MAP_VH

`define ADDR_W          20
`define ADDR_TOP        20'hFFFFF
`define ADDR_BOTTOM     20'h00000
`define PERIPH_LAST     20'h003FF
`define RAM_BASE        20'h00400
`define SPECIAL_FIRST   20'hFFE00
`define SPECIAL_LAST    20'hFFFDB
`define FIXED_VEC_FIRST 20'hFFFDC
`define ROM_SIZE_DEF    20'h10000
`define RAM_SIZE_DEF    20'h02800

// region codes
`define REG_PERIPH      3'h0
`define REG_RAM         3'h1
`define REG_ROM         3'h2
`define REG_SPECIAL     3'h3
`define REG_FIXED       3'h4
`define REG_UNMAPPED    3'h5

// port register selector codes (4 bits)
`define SEL_DATA0       4'h0
`define SEL_DATA1       4'h1
`define SEL_DATA2       4'h2
`define SEL_DATA3       4'h3
`define SEL_PTR0        4'h4
`define SEL_PTR1        4'h5
`define SEL_FRAME       4'h6
`define SEL_VTB         4'h7
`define SEL_PC          4'h8
`define SEL_USP         4'h9
`define SEL_ISP         4'hA
`define SEL_FLAGS       4'hB

// write size codes
`define SZ_WORD         2'h0
`define SZ_LOW_BYTE     2'h1
`define SZ_HIGH_BYTE    2'h2
`define SZ_PAIR         2'h3

// flag register bit positions
`define FLAG_BANK       0
`define FLAG_STACK      1

`define RESET_VALUE     20'h00000

`endif

// ---- bench/cpu_register_file_assertions.sv ----
// port checks for the register file
`timescale 1ns/10ps
module cpu_register_file_assertions #(
	parameter [19:0] ROM_SIZE = 20'h10000,
	parameter [19:0] RAM_SIZE = 20'h02800
) (
	input wire        clk,
	input wire        rst,
	input wire [3:0]  addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire [19:0] mem_addr,
	input wire [2:0]  mem_region,
	input wire        bank_sel_out
);
	// region bounds follow the size parameters
	wire [19:0] rom_lo = 20'h00000 - ROM_SIZE;
	wire [19:0] ram_hi = 20'h00400 + RAM_SIZE;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	idle_read_a: assert property (!rd |=> rdata == 32'h0)
		else $error("read data not zero");
	refused_read_a: assert property (rd && addr >= 4'hC |=> rdata == 32'h0)
		else $error("refused read not zero");
	periph_area_a: assert property (mem_addr <= 20'h003FF |=> mem_region == 3'h0)
		else $error("peripheral decode");
	ram_area_a: assert property (mem_addr >= 20'h00400 && mem_addr < ram_hi
		|=> mem_region == 3'h1)
		else $error("ram decode");
	rom_area_a: assert property (mem_addr >= rom_lo && mem_addr < 20'hFFE00
		|=> mem_region == 3'h2)
		else $error("rom decode");
	special_page_a: assert property (mem_addr inside {[20'hFFE00:20'hFFFDB]}
		|=> mem_region == 3'h3)
		else $error("special page decode");
	fixed_vector_a: assert property (mem_addr >= 20'hFFFDC |=> mem_region == 3'h4)
		else $error("fixed vector decode");
	gap_area_a: assert property (mem_addr >= ram_hi && mem_addr < rom_lo
		|=> mem_region == 3'h5)
		else $error("gap decode");
	bank_flag_a: assert property (wr && addr == 4'hB
		|=> ##1 bank_sel_out == $past(wdata[0], 2))
		else $error("bank flag");
endmodule // cpu_register_file_assertions

// ---- bench/datapath_model.sv ----
// datapath model: drives the register port of the core
`timescale 1ns/10ps
module datapath_model (
	input  wire         clk,
	input  wire  [31:0] rdata,
	output logic [3:0]  addr = 4'h0,
	output logic [31:0] wdata = 32'h0,
	output logic [1:0]  wsize = 2'h0,
	output logic        wr = 1'b0,
	output logic        rd = 1'b0
);
	// strobe one cycle, then a gap so no signal changes twice per step
	task automatic put(input logic [3:0] a, input logic [1:0] s, input logic [31:0] d);
		addr <= a;
		wsize <= s;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
		@(posedge clk);
	endtask
	// read data are taken in the one cycle they stand
	task automatic get(input logic [3:0] a, input logic [1:0] s, output logic [31:0] q);
		addr <= a;
		wsize <= s;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		q = rdata;
	endtask
endmodule // datapath_model

// ---- bench/cpu_register_file_tb.sv ----
// self-checking bench for register file and address decoder
`timescale 1ns/10ps
module cpu_register_file_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr, a_sel = 4'h0, b_sel = 4'h4;
	logic [1:0]  wsize, a_size = 2'h3, b_size = 2'h0;
	logic [31:0] wdata, rdata, src_a, src_b, q;
	logic        wr, rd, bank_sel_out;
	logic [19:0] mem_addr = 20'h0, pc_out, vector_base_out;
	logic [15:0] stack_pointer, frame_base_out;
	logic [2:0]  mem_region;
	logic [19:0] ra[12] = '{20'h0, 20'h3FF, 20'h400, 20'h2BFF, 20'h2C00,
		20'hEFFFF, 20'hF0000, 20'hFFDFF, 20'hFFE00, 20'hFFFDB, 20'hFFFDC, 20'hFFFFF};
	logic [2:0]  rr[12] = '{0, 0, 1, 1, 5, 5, 2, 2, 3, 3, 4, 4};
	int          n_fail = 0;
	int          check_count = 0;
	always #2 clk = ~clk;
	cpu_register_file dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wsize(wsize), .wr(wr), .rd(rd), .rdata(rdata), .src_a_sel(a_sel),
		.src_a_size(a_size), .src_b_sel(b_sel), .src_b_size(b_size),
		.src_a(src_a), .src_b(src_b), .mem_addr(mem_addr), .mem_region(mem_region),
		.pc_out(pc_out), .stack_pointer(stack_pointer),
		.frame_base_out(frame_base_out), .vector_base_out(vector_base_out),
		.bank_sel_out(bank_sel_out));
	datapath_model pm (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wsize(wsize), .wr(wr), .rd(rd));
	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard: every wait below is a fixed count
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		pm.put(4'h0, 2'h1, 32'hAB);
		pm.put(4'h0, 2'h2, 32'hCD);
		pm.get(4'h0, 2'h0, q); check("byte halves", q, 32'hCDAB);
		pm.get(4'h0, 2'h2, q); check("high byte", q, 32'hCD);
		for (int i = 1; i < 8; i++)
			pm.put(i[3:0], 2'h0, 32'hA1110 + i);
		for (int i = 1; i < 8; i++) begin
			pm.get(i[3:0], 2'h0, q);
			check("word", q, (32'hA1110 + i) & (i == 7 ? 32'hFFFFF : 32'hFFFF));
		end
		pm.get(4'h0, 2'h3, q); check("data pair", q, 32'h1112CDAB);
		pm.get(4'h1, 2'h3, q); check("data pair 1", q, 32'h11131111);
		pm.get(4'h4, 2'h3, q); check("pointer pair", q, 32'h11151114);
		check("operand a", src_a, 32'h1112CDAB);
		check("operand b", src_b, 32'h1114);
		pm.put(4'h8, 2'h0, 32'h54321);
		@(posedge clk);
		check("pc", pc_out, 32'h54321);
		check("frame", frame_base_out, 32'h1116);
		check("table base", vector_base_out, 32'hA1117);
		pm.put(4'h9, 2'h0, 32'h2222);
		pm.put(4'hA, 2'h0, 32'h3333);
		pm.put(4'hB, 2'h0, 32'h1);
		@(posedge clk);
		check("bank flag", bank_sel_out, 32'h1);
		check("isp", stack_pointer, 32'h3333);
		pm.get(4'h0, 2'h0, q); check("second bank", q, 32'h0);
		pm.put(4'h0, 2'h0, 32'h5A5A);
		pm.put(4'hB, 2'h0, 32'h2);
		@(posedge clk);
		check("usp", stack_pointer, 32'h2222);
		pm.get(4'h0, 2'h0, q); check("first bank", q, 32'hCDAB);
		pm.put(4'hC, 2'h0, 32'hFFFF);
		pm.get(4'hC, 2'h0, q); check("refused", q, 32'h0);
		foreach (ra[i]) begin
			mem_addr <= ra[i];
			repeat (2) @(posedge clk);
			check("region", mem_region, rr[i]);
		end
		report_and_stop;
	end
endmodule // cpu_register_file_tb
bind cpu_register_file cpu_register_file_assertions #(.ROM_SIZE(ROM_SIZE),
	.RAM_SIZE(RAM_SIZE)) chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .mem_addr(mem_addr),
	.mem_region(mem_region), .bank_sel_out(bank_sel_out));
